// >>> rtl/ufb_baud.sv
// baud prescaler producing one tick per bit time
`timescale 1ns/1ps
`default_nettype none
module ufb_baud (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic [11:0] divisor,
    input wire logic reload,
    input wire logic [4:0] ovs,
    output logic bit_tick,
    output logic half_tick
);
    import ufb_pkg::*;
    // prescaler count and oversample count
    logic [11:0] pre_cnt;
    logic [4:0] ovs_cnt;
    wire pre_wrap = (pre_cnt == 12'h000);
    wire ovs_last = (ovs_cnt == ovs - 5'h01);
    wire ovs_half = (ovs_cnt == (ovs >> 1) - 5'h01);
    // prescaler divides by divisor+1, oversample by 16 or 8
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_cnt <= 12'h000;
            ovs_cnt <= 5'h00;
        end else if (ce) begin
            if (reload) begin
                pre_cnt <= divisor;
                ovs_cnt <= 5'h00;
            end else if (pre_wrap) begin
                pre_cnt <= divisor;
                ovs_cnt <= ovs_last ? 5'h00 : ovs_cnt + 5'h01;
            end else begin
                pre_cnt <= pre_cnt - 12'h001;
            end
        end
    end
    // ticks are single cycles when the oversample counter hits its marks
    assign bit_tick = ce && !reload && pre_wrap && ovs_last;
    assign half_tick = ce && !reload && pre_wrap && ovs_half;
endmodule
`default_nettype wire

// >>> rtl/ufb_parity.sv
// parity over the active data bits of one character
`timescale 1ns/1ps
`default_nettype none
module ufb_parity (
    input wire logic [8:0] data,
    input wire logic [3:0] nbits,
    input wire logic odd,
    output logic parity
);
    import ufb_pkg::*;
    logic [8:0] used;
    // keep only bits below the character size
    genvar i;
    generate
        for (i = 0; i < 9; i++) begin : g_mask
            assign used[i] = data[i] & (4'(i) < nbits);
        end
    endgenerate
    assign parity = (^used) ^ odd;
endmodule
`default_nettype wire

// >>> rtl/ufb_pkg.sv
// package with register map, field layout and timing constants of the serial port
package ufb_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_FRAME = 8'h00;
    localparam logic [7:0] ADDR_BAUD_HIGH = 8'h04;
    localparam logic [7:0] ADDR_BAUD_LOW = 8'h08;
    localparam logic [7:0] ADDR_CTRL = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
    localparam logic [7:0] ADDR_TX_DATA = 8'h1C;
    localparam logic [7:0] ADDR_RX_DATA = 8'h20;
    // frame format field positions
    localparam int MODE_HI = 7;
    localparam int MODE_LO = 6;
    localparam int PAR_HI = 5;
    localparam int PAR_LO = 4;
    localparam int STOP_BIT = 3;
    localparam int SIZE_HI = 2;
    localparam int SIZE_LO = 1;
    localparam int POL_BIT = 0;
    // control register bits
    localparam int CTRL_TXEN = 0;
    localparam int CTRL_RXEN = 1;
    localparam int CTRL_DBL = 2;
    localparam int CTRL_SIZE2 = 3;
    // interrupt status bits
    localparam int IRQ_TXDONE = 0;
    localparam int IRQ_RXDONE = 1;
    localparam int IRQ_PARERR = 2;
    localparam int IRQ_W = 3;
    // reset values and the write mask of the divisor high register
    localparam logic [7:0] FRAME_RESET = 8'h06;
    localparam logic [11:0] BAUD_RESET = 12'h000;
    localparam logic [3:0] BAUD_HIGH_MASK = 4'hF;
    // oversampling ratios
    localparam logic [4:0] OVS_NORMAL = 5'h10;
    localparam logic [4:0] OVS_DOUBLE = 5'h08;
    // mode encodings
    typedef enum logic [1:0] {
        UFB_ASYNC = 2'b00,
        UFB_SYNC = 2'b01,
        UFB_RSVD = 2'b10,
        UFB_MSPI = 2'b11
    } ufb_mode_e;
    // parity encodings
    localparam logic [1:0] PAR_OFF = 2'b00;
    localparam logic [1:0] PAR_EVEN = 2'b10;
    localparam logic [1:0] PAR_ODD = 2'b11;
    // character size codes
    localparam logic [2:0] SIZE_NINE = 3'b111;
    localparam logic [3:0] BITS_NINE = 4'h9;
    localparam logic [3:0] BITS_FIVE = 4'h5;
endpackage

// >>> rtl/ufb_usart.sv
// serial port frame format, baud generator, shift logic and apb registers
// Notes on behaviour
// [RULE1] mode 00 async, 01 sync, 11 spi; mode 11 has no spi logic here and frames as async at x16
// [RULE2] parity 00 off, 10 even, 11 odd
// [RULE3] transmitter appends computed parity bit
// [RULE4] receiver checks parity, flags mismatch
// [RULE5] stop select gives one or two stops
// [RULE6] receiver ignores stop select
// [RULE7] size code gives 5-9 data bits
// [RULE8] polarity picks sync clock edges
// [RULE9] software keeps polarity zero in async
// [RULE10] twelve bit divisor from high/low
// [RULE11] divisor bits 15:12 read zero
// [RULE12] low byte write reloads prescaler
// [RULE13] software avoids divisor change mid frame
// [RULE14] double speed divides by eight
// [RULE15] parity flag follows buffered character
// [RULE16] rate is clock/(16 or 8)/(div+1)
// [RULE17] reset: async, no parity, 8 bits
//
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module ufb_usart (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic receive_pin,
    output logic transmit_pin,
    input wire logic sync_clock_pin_in,
    output logic sync_clock_pin_out,
    output logic sync_clock_pin_oe
);
    import ufb_pkg::*;
    ////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0] frame_format_control;
    logic [3:0] baud_divisor_high;
    logic [7:0] baud_divisor_low;
    logic [3:0] ctrl;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [8:0] tx_buf;
    logic tx_full;
    logic [8:0] rx_buf;
    logic rx_full;
    logic parity_error_flag;
    // apb decode
    wire acc = psel && penable;
    wire wr = acc && pwrite && ce;
    wire rd = acc && !pwrite && ce;
    wire hit_frame = (paddr == ADDR_FRAME);
    wire hit_bh = (paddr == ADDR_BAUD_HIGH);
    wire hit_bl = (paddr == ADDR_BAUD_LOW);
    wire hit_ctrl = (paddr == ADDR_CTRL);
    wire hit_stat = (paddr == ADDR_STATUS);
    wire hit_is = (paddr == ADDR_IRQ_STAT);
    wire hit_im = (paddr == ADDR_IRQ_MASK);
    wire hit_tx = (paddr == ADDR_TX_DATA);
    wire hit_rx = (paddr == ADDR_RX_DATA);
    wire mapped = hit_frame || hit_bh || hit_bl || hit_ctrl || hit_stat ||
                  hit_is || hit_im || hit_tx || hit_rx;
    assign pready = 1'b1;
    assign pslverr = acc && !mapped;
    // decoded frame fields
    wire [1:0] operating_mode_select = frame_format_control[MODE_HI:MODE_LO];
    wire [1:0] parity_mode = frame_format_control[PAR_HI:PAR_LO];
    wire stop_bit_select = frame_format_control[STOP_BIT];
    wire [1:0] char_size_low_bits = frame_format_control[SIZE_HI:SIZE_LO];
    wire sync_clock_polarity = frame_format_control[POL_BIT];
    wire char_size_high_bit = ctrl[CTRL_SIZE2];
    wire double_speed = ctrl[CTRL_DBL];
    wire tx_en = ctrl[CTRL_TXEN];
    wire rx_en = ctrl[CTRL_RXEN];
    wire [2:0] size_code = {char_size_high_bit, char_size_low_bits};
    wire [11:0] baud_divisor = {baud_divisor_high, baud_divisor_low};
    wire is_sync = (operating_mode_select == UFB_SYNC); // [RULE1]
    wire is_async = (operating_mode_select == UFB_ASYNC); // [RULE1]
    wire par_on = parity_mode[1]; // [RULE2]
    wire par_odd = (parity_mode == PAR_ODD); // [RULE2]
    // reserved size codes fall back to eight bits
    wire [3:0] nbits = (size_code == SIZE_NINE) ? BITS_NINE :
                       (size_code[2] ? BITS_NINE - 4'h1 :
                        BITS_FIVE + {2'b00, size_code[1:0]}); // [RULE7]
    wire [4:0] ovs = (is_async && double_speed) ? OVS_DOUBLE
                                                 : OVS_NORMAL; // [RULE14]
    ////////////////////////////////////////////////////////////////////////
    // baud generator
    wire reload = wr && hit_bl; // [RULE12]
    // the low byte being written goes straight into the prescaler
    wire [11:0] next_divisor = reload ? {baud_divisor_high, pwdata[7:0]}
                                      : baud_divisor; // [RULE12]
    logic bit_tick;
    logic half_tick;
    ufb_baud u_baud (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .divisor(next_divisor),
        .reload(reload),
        .ovs(ovs),
        .bit_tick(bit_tick),
        .half_tick(half_tick)
    ); // [RULE16]
    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic rx_s1, rx_s2, xck_s1, xck_s2, xck_d;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_s1 <= 1'b1;
            rx_s2 <= 1'b1;
            xck_s1 <= 1'b0;
            xck_s2 <= 1'b0;
            xck_d <= 1'b0;
        end else if (ce) begin
            rx_s1 <= receive_pin;
            rx_s2 <= rx_s1;
            xck_s1 <= sync_clock_pin_in;
            xck_s2 <= xck_s1;
            xck_d <= xck_s2;
        end
    end
    // external sync clock edges; polarity picks which one changes data
    wire xck_rise = xck_s2 && !xck_d;
    wire xck_fall = !xck_s2 && xck_d;
    wire sync_chg = sync_clock_polarity ? xck_fall : xck_rise; // [RULE8]
    wire sync_smp = sync_clock_polarity ? xck_rise : xck_fall; // [RULE8]
    // the port is a sync slave: it never drives the clock pin
    assign sync_clock_pin_out = 1'b0;
    assign sync_clock_pin_oe = 1'b0;
    wire tx_step = is_sync ? sync_chg : bit_tick;
    wire rx_smp = is_sync ? sync_smp : half_tick;
    ////////////////////////////////////////////////////////////////////////
    // transmitter: start, data, optional parity, one or two stops
    logic [8:0] tx_sh;
    logic [3:0] tx_cnt;
    logic [3:0] tx_len;
    logic tx_busy;
    logic tx_par;
    // parity frozen at load, so a new buffer write cannot alter it
    logic tx_par_q;
    ufb_parity u_txpar (
        .data(tx_buf),
        .nbits(nbits),
        .odd(par_odd),
        .parity(tx_par)
    ); // [RULE3]
    wire [3:0] frame_len = nbits + {3'b000, par_on} + 4'h1 +
                           {3'b000, stop_bit_select}; // [RULE5]
    wire tx_load = tx_en && tx_full && !tx_busy && tx_step;
    wire tx_done = tx_busy && tx_step && (tx_cnt == tx_len);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_busy <= 1'b0;
            tx_cnt <= 4'h0;
            tx_len <= 4'h0;
            tx_sh <= 9'h000;
            tx_par_q <= 1'b0;
            transmit_pin <= 1'b1;
        end else if (ce) begin
            if (tx_load) begin
                tx_busy <= 1'b1;
                tx_cnt <= 4'h0;
                tx_len <= frame_len;
                tx_sh <= tx_buf;
                tx_par_q <= tx_par; // [RULE3]
                transmit_pin <= 1'b0;
            end else if (tx_done) begin
                tx_busy <= 1'b0;
                transmit_pin <= 1'b1;
            end else if (tx_busy && tx_step) begin
                tx_cnt <= tx_cnt + 4'h1;
                if (tx_cnt < nbits) begin
                    transmit_pin <= tx_sh[0];
                    tx_sh <= {1'b0, tx_sh[8:1]};
                end else if (par_on && tx_cnt == nbits) begin
                    transmit_pin <= tx_par_q; // [RULE3]
                end else begin
                    transmit_pin <= 1'b1; // [RULE5]
                end
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // receiver: stop select is never consulted here [RULE6]
    logic rx_busy;
    logic [3:0] rx_cnt;
    logic [8:0] rx_sh;
    logic rx_par;
    wire rx_start = rx_en && !rx_busy && !rx_s2 && rx_smp;
    wire rx_last = rx_busy && rx_smp &&
                   (rx_cnt == nbits + {3'b000, par_on} + 4'h1);
    // shift right aligns first bit at index zero once nbits are in
    wire [8:0] rx_word = rx_sh >> (BITS_NINE - nbits);
    ufb_parity u_rxpar (
        .data(rx_word),
        .nbits(nbits),
        .odd(par_odd),
        .parity(rx_par)
    ); // [RULE4]
    logic rx_pbit;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_busy <= 1'b0;
            rx_cnt <= 4'h0;
            rx_sh <= 9'h000;
            rx_pbit <= 1'b0;
        end else if (ce) begin
            if (rx_start) begin
                rx_busy <= 1'b1;
                rx_cnt <= 4'h1;
            end else if (rx_last) begin
                rx_busy <= 1'b0;
            end else if (rx_busy && rx_smp) begin
                rx_cnt <= rx_cnt + 4'h1;
                if (rx_cnt <= nbits) begin
                    rx_sh <= {rx_s2, rx_sh[8:1]};
                end else begin
                    rx_pbit <= rx_s2;
                end
            end
        end
    end
    wire rx_bad = par_on && (rx_pbit != rx_par); // [RULE4]
    wire rx_read = rd && hit_rx;
    ////////////////////////////////////////////////////////////////////////
    // data buffers and parity flag tied to the buffered character
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_buf <= 9'h000;
            tx_full <= 1'b0;
            rx_buf <= 9'h000;
            rx_full <= 1'b0;
            parity_error_flag <= 1'b0;
        end else if (ce) begin
            if (wr && hit_tx && !tx_full) begin
                tx_buf <= pwdata[8:0];
                tx_full <= 1'b1;
            end else if (tx_load) begin
                tx_full <= 1'b0;
            end
            if (rx_last) begin
                rx_buf <= rx_word;
                rx_full <= 1'b1;
                parity_error_flag <= rx_bad; // [RULE15]
            end else if (rx_read || !rx_en) begin
                rx_full <= 1'b0;
                parity_error_flag <= 1'b0; // [RULE15]
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_format_control <= FRAME_RESET; // [RULE17]
            baud_divisor_high <= BAUD_RESET[11:8]; // [RULE17]
            baud_divisor_low <= BAUD_RESET[7:0];
            ctrl <= 4'h0;
            irq_mask <= '0;
        end else if (wr) begin
            if (hit_frame) begin
                frame_format_control <= pwdata[7:0];
            end else if (hit_bh) begin
                baud_divisor_high <= pwdata[3:0] & BAUD_HIGH_MASK; // [RULE10]
            end else if (hit_bl) begin
                baud_divisor_low <= pwdata[7:0]; // [RULE10]
            end else if (hit_ctrl) begin
                ctrl <= pwdata[3:0];
            end else if (hit_im) begin
                irq_mask <= pwdata[IRQ_W-1:0];
            end
        end
    end
    // sticky events; a new event wins over a write-one clear
    wire [IRQ_W-1:0] ev = {rx_last && rx_bad, rx_last, tx_done};
    wire [IRQ_W-1:0] clr = (wr && hit_is) ? pwdata[IRQ_W-1:0] : '0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat <= '0;
        end else if (ce) begin
            irq_stat <= (irq_stat & ~clr) | ev;
        end
    end
    assign irq = |(irq_stat & irq_mask);
    ////////////////////////////////////////////////////////////////////////
    // read mux; reserved divisor bits read zero [RULE11]
    wire [31:0] rdata =
        hit_frame ? {24'h000000, frame_format_control} :
        hit_bh ? {28'h0000000, baud_divisor_high} :
        hit_bl ? {24'h000000, baud_divisor_low} :
        hit_ctrl ? {28'h0000000, ctrl} :
        hit_stat ? {27'h0000000, parity_error_flag, rx_busy, tx_busy,
                    rx_full, tx_full} :
        hit_is ? {29'h00000000, irq_stat} :
        hit_im ? {29'h00000000, irq_mask} :
        hit_rx ? {23'h000000, rx_buf} : 32'h00000000;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (ce && psel && !penable && !pwrite) begin
            prdata <= rdata;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // checks share one clock and reset; a frame opens at load, closes at done
    default clocking chk_cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_tx_open;
        ce && tx_load;
    endsequence
    sequence s_tx_close;
        ce && tx_done;
    endsequence
    AST_RELOAD: assert property (reload |=> !bit_tick) // [RULE12]
        else $error("tick right after reload");
    AST_RESERVED: assert property (prdata[31:9] == 23'h000000) // [RULE11]
        else $error("reserved bits not zero");
    AST_PARFLAG: assert property (ce && rx_last |=> // [RULE15]
        parity_error_flag == $past(rx_bad)) else $error("parity flag wrong");
    AST_NOPAR: assert property (!par_on && ce && rx_last |=> // [RULE4]
        !parity_error_flag) else $error("parity flag without parity");
    AST_STARTBIT: assert property (s_tx_open |=> !transmit_pin) // [RULE3]
        else $error("no start bit");
    AST_STOPHIGH: assert property (s_tx_close |=> transmit_pin) // [RULE5]
        else $error("stop not high");
    AST_OVS: assert property (!is_async |-> ovs == OVS_NORMAL) // [RULE14]
        else $error("double speed in sync");
    AST_IRQ: assert property (ce && |ev |=> |irq_stat) // [RULE4]
        else $error("event lost");
endmodule
`default_nettype wire

// >>> verification/ufb_peer.sv
// remote serial peer that drives the receive line and samples the transmit line
`timescale 1ns/1ps
`default_nettype none
module ufb_peer (
    input wire logic pclk,
    input wire logic transmit_pin,
    output logic receive_pin,
    output logic sync_clock_pin
);
    // line idles high between frames, as a uart line with pull-up does
    initial receive_pin = 1'b1;
    // sync clock rests at its idle level outside frames
    initial sync_clock_pin = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // send one frame: start, data lsb first, optional parity, one stop
    task automatic send(input logic [8:0] d, input int n, input logic [1:0] par,
                        input logic bad, input int bt);
        logic p;
        p = ^(d & ((9'h001 << n) - 9'h001));
        if (par[0]) begin
            p = ~p; // odd parity
        end
        if (bad) begin
            p = ~p; // deliberate parity fault
        end
        @(posedge pclk);
        receive_pin <= 1'b0;
        repeat (bt) @(posedge pclk);
        for (int i = 0; i < n; i++) begin
            receive_pin <= d[i];
            repeat (bt) @(posedge pclk);
        end
        // parity bit sits between data and stop
        if (par[1]) begin
            receive_pin <= p;
            repeat (bt) @(posedge pclk);
        end
        receive_pin <= 1'b1;
        repeat (bt) @(posedge pclk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // capture one frame; start bit length is measured, bit0 must be one
    task automatic capture(input int n, input logic pe, output logic [8:0] d,
                           output logic p, output logic s, output int bt);
        d = 9'h000;
        p = 1'b0;
        bt = 0;
        @(negedge transmit_pin);
        @(posedge pclk);
        while (transmit_pin === 1'b0) begin
            bt++;
            @(posedge pclk);
        end
        repeat (bt / 2 - 1) @(posedge pclk);
        for (int i = 0; i < n; i++) begin
            d[i] = transmit_pin;
            repeat (bt) @(posedge pclk);
        end
        if (pe) begin
            p = transmit_pin;
            repeat (bt) @(posedge pclk);
        end
        s = transmit_pin;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // clock one synchronous frame: launch edge, then sample edge, n times
    task automatic sync_frame(input logic pol, input int n,
                              output logic [10:0] b);
        b = 11'h000;
        sync_clock_pin <= pol;
        repeat (8) @(posedge pclk);
        for (int i = 0; i < n; i++) begin
            sync_clock_pin <= ~pol; // device changes data here
            repeat (8) @(posedge pclk);
            b[i] = transmit_pin;
            sync_clock_pin <= pol; // peer samples at this edge
            repeat (8) @(posedge pclk);
        end
    endtask
endmodule
`default_nettype wire

// >>> verification/ufb_usart_tb_top.sv
// self-checking testbench of the serial port registers and frames
`timescale 1ns/1ps
`default_nettype none
module ufb_usart_tb_top;
    import ufb_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, irq, rx_line, tx_line, sck_o, sck_oe, sck_i;
    int fail_count = 0;
    int n_tests = 0;
    int cyc = 0;
    // transmit cases: frame, ctrl, divisor, data, bits, parity, stops, bit time
    logic [7:0] tf [5] = '{8'h2E, 8'h30, 8'h06, 8'h24, 8'h3A};
    logic [7:0] tc [5] = '{8'h01, 8'h05, 8'h09, 8'h01, 8'h05};
    logic [11:0] tv [5] = '{12'h001, 12'h002, 12'h000, 12'h000, 12'h000};
    logic [8:0] td [5] = '{9'h0A5, 9'h013, 9'h155, 9'h04B, 9'h02D};
    int tn [5] = '{8, 5, 9, 7, 6};
    int tb [5] = '{32, 24, 16, 16, 8};

    // 40 MHz clock
    always #12.5 pclk = ~pclk;
    // cycle counter for frame length measurement
    always @(posedge pclk) cyc <= cyc + 1;

    ufb_usart dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .receive_pin(rx_line), .transmit_pin(tx_line),
        .sync_clock_pin_in(sck_i), .sync_clock_pin_out(sck_o),
        .sync_clock_pin_oe(sck_oe));
    ufb_peer peer (.pclk(pclk), .transmit_pin(tx_line),
        .receive_pin(rx_line), .sync_clock_pin(sck_i));

    ////////////////////////////////////////////////////////////////////////
    // compare and report
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // verdict and end of run
    task automatic complete_run;
        if (fail_count == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // one apb transfer: setup, access until pready, then release
    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [31:0] d, output logic [31:0] rd,
                        output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        xfer(a, 1'b1, d, r, e);
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a,
                          input logic [31:0] e);
        logic [31:0] r;
        logic er;
        xfer(a, 1'b0, 32'h0, r, er);
        chk(nm, e, r);
    endtask

    // poll status until the receive buffer is full, bounded
    task automatic wait_rx;
        logic [31:0] r;
        logic e;
        for (int i = 0; i < 40; i++) begin
            xfer(ADDR_STATUS, 1'b0, 32'h0, r, e);
            if (r[1] === 1'b1) begin
                break;
            end
        end
        chk("rx_full", 32'h1, {31'h0, r[1]});
    endtask

    // watchdog: all tests need well under 40000 cycles
    initial begin
        repeat (40000) @(posedge pclk);
        fail_count++;
        complete_run();
    end

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        logic [31:0] r;
        logic e, p, s;
        logic [8:0] d;
        logic [10:0] sb;
        int bm, t0, t1, tol, ln, pe, ns;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk("frame_rst", ADDR_FRAME, 32'h06);
        rd_chk("high_rst", ADDR_BAUD_HIGH, 32'h0);
        rd_chk("low_rst", ADDR_BAUD_LOW, 32'h0);
        // every mode code is stored and read back
        for (int m = 0; m < 4; m++) begin
            wr(ADDR_FRAME, {24'h0, 2'(m), 6'h06});
            rd_chk("mode", ADDR_FRAME, {24'h0, 2'(m), 6'h06});
        end
        wr(ADDR_BAUD_HIGH, 32'hFF);
        rd_chk("high_rsvd", ADDR_BAUD_HIGH, 32'h0F);
        xfer(8'h24, 1'b0, 32'h0, r, e);
        chk("unmapped_err", 32'h1, {31'h0, e});
        chk("unmapped_data", 32'h0, r);
        // transmit frames in several formats
        for (int k = 0; k < 5; k++) begin
            pe = tf[k][5];
            ns = tf[k][3] ? 2 : 1;
            wr(ADDR_FRAME, {24'h0, tf[k]});
            wr(ADDR_BAUD_HIGH, {28'h0, tv[k][11:8]});
            wr(ADDR_BAUD_LOW, {24'h0, tv[k][7:0]});
            wr(ADDR_CTRL, {24'h0, tc[k]});
            wr(ADDR_IRQ_MASK, 32'h1);
            wr(ADDR_IRQ_STAT, 32'h7);
            fork
                peer.capture(tn[k], pe[0], d, p, s, bm);
                begin
                    @(negedge tx_line);
                    t0 = cyc;
                    while (irq !== 1'b1) @(posedge pclk);
                    t1 = cyc;
                end
                wr(ADDR_TX_DATA, {23'h0, td[k]});
            join
            chk("tx_bit_time", tb[k], bm);
            chk("tx_data", td[k], d);
            chk("tx_parity", pe ? (^td[k]) ^ tf[k][4] : 1'b0, p);
            chk("tx_stop", 32'h1, s);
            ln = (t1 - t0) - (1 + tn[k] + pe + ns) * tb[k];
            tol = tb[k] / 2 + 4;
            chk("tx_len", 32'h1, 32'(ln <= tol && ln >= -tol));
        end
        // synchronous transmit under both clock polarities
        for (int q = 0; q < 2; q++) begin
            wr(ADDR_FRAME, {24'h0, 8'h46 | 8'(q)});
            wr(ADDR_CTRL, 32'h1);
            wr(ADDR_TX_DATA, 32'hC5);
            peer.sync_frame(1'(q), 11, sb);
            chk("sync_frame", {21'h0, 2'b11, 8'hC5, 1'b0}, sb);
            chk("sck_drive", 32'h0, {30'h0, sck_oe, sck_o});
        end
        // receive with two-stop setting while the peer sends one stop
        wr(ADDR_FRAME, 32'h2E);
        wr(ADDR_BAUD_HIGH, 32'h0);
        wr(ADDR_BAUD_LOW, 32'h0);
        wr(ADDR_CTRL, 32'h2);
        wr(ADDR_IRQ_MASK, 32'h0);
        wr(ADDR_IRQ_STAT, 32'h7);
        peer.send(9'h05A, 8, 2'b10, 1'b0, 16);
        wait_rx();
        rd_chk("par_ok", ADDR_STATUS, 32'h2);
        rd_chk("rx_data", ADDR_RX_DATA, 32'h5A);
        wr(ADDR_IRQ_STAT, 32'h7);
        peer.send(9'h0C3, 8, 2'b10, 1'b1, 16);
        wait_rx();
        rd_chk("par_err", ADDR_STATUS, 32'h12);
        rd_chk("irq_par", ADDR_IRQ_STAT, 32'h6);
        chk("irq_masked", 32'h0, {31'h0, irq});
        wr(ADDR_IRQ_MASK, 32'h4);
        @(negedge pclk);
        chk("irq_on", 32'h1, {31'h0, irq});
        rd_chk("rx_bad", ADDR_RX_DATA, 32'hC3);
        rd_chk("par_clr", ADDR_STATUS, 32'h0);
        wr(ADDR_IRQ_STAT, 32'h4);
        @(negedge pclk);
        chk("irq_off", 32'h0, {31'h0, irq});
        // odd parity receive, good frame
        wr(ADDR_FRAME, 32'h36);
        peer.send(9'h081, 8, 2'b11, 1'b0, 16);
        wait_rx();
        rd_chk("odd_ok", ADDR_STATUS, 32'h2);
        rd_chk("rx_odd", ADDR_RX_DATA, 32'h81);
        complete_run();
    end
endmodule
`default_nettype wire
